// ---- lpw_bkp.v ----
`timescale 1ns/1ps
`include "lpw_defines.vh"

module lpw_bkp #(
    parameter WORDS = `LPW_BKP_WORDS
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        clr,
    input  wire        we,
    input  wire [4:0]  waddr,
    input  wire [31:0] wdata,
    input  wire [4:0]  raddr,
    output wire [31:0] rdata
);
    reg [31:0] mem_q [0:WORDS-1];

    genvar i;
    generate
        for (i = 0; i < WORDS; i = i + 1)
        begin : g_word
            localparam [4:0] IDX = i;
            always @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    mem_q[i] <= 32'h0;
                else if (clr)
                    mem_q[i] <= 32'h0;
                else if (we && waddr == IDX)
                    mem_q[i] <= wdata;
            end
        end
    endgenerate

    assign rdata = (raddr < WORDS) ? mem_q[raddr] : 32'h0;
endmodule

// ---- lpw_ctrl.v ----
`timescale 1ns/1ps
`include "lpw_defines.vh"

module lpw_ctrl #(
    parameter NPER  = 8,
    parameter NEXTI = 16
) (
    input  wire             CLK,
    input  wire             ARST_N,
    input  wire             HSEL,
    input  wire [11:0]      HADDR,
    input  wire [1:0]       HTRANS,
    input  wire             HWRITE,
    input  wire [2:0]       HSIZE,
    input  wire [31:0]      HWDATA,
    input  wire             HREADY,
    output wire             HREADYOUT,
    output wire             HRESP,
    output wire [31:0]      HRDATA,
    input  wire             CORE_SLEEP_REQ,
    input  wire [NPER-1:0]  PERIPH_IRQ,
    input  wire [NPER-1:0]  PERIPH_WAKE,
    input  wire [NEXTI-1:0] EXTERNAL_INTERRUPT_LINE_LINE,
    input  wire             WAKE_PIN2,
    input  wire             WAKE_PIN3,
    input  wire             CAL_ALARM_A,
    input  wire             CAL_ALARM_B,
    input  wire             CAL_WAKE_TIMER,
    input  wire             CAL_TAMPER,
    input  wire             CAL_TIMESTAMP,
    input  wire             EXT_RESET_PIN_N,
    input  wire             WATCHDOG_RESET,
    output wire             CORE_HALT,
    output wire             CORE_CLK_EN,
    output wire [NPER-1:0]  PCLK_EN,
    output wire             REF_EN,
    output wire             VCORE_EN,
    output wire [1:0]       REG_RANGE,
    output wire             LP_RUN,
    output wire             STBY_RESET_REQ,
    output wire             IRQ
);
    localparam [2:0] ST_RUN   = 3'h0;
    localparam [2:0] ST_SLEEP = 3'h1;
    localparam [2:0] ST_STOP  = 3'h2;
    localparam [2:0] ST_STBY  = 3'h3;
    localparam [2:0] ST_WAKE  = 3'h4;

    localparam        AW       = NEXTI + 9;
    localparam [15:0] REF_CYC  = `LPW_REF_CYC;
    localparam [15:0] SETL_CYC = `LPW_SETTLE_CYC;

    // Async input synchronisers
    wire [AW-1:0] asy_in;
    reg  [AW-1:0] sy1_q;
    reg  [AW-1:0] sy2_q;
    reg  [AW-1:0] sy3_q;

    assign asy_in = {WATCHDOG_RESET, ~EXT_RESET_PIN_N, CAL_TIMESTAMP,
                     CAL_TAMPER, CAL_WAKE_TIMER, CAL_ALARM_B,
                     CAL_ALARM_A, WAKE_PIN3, WAKE_PIN2, EXTERNAL_INTERRUPT_LINE_LINE};

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sy1_q <= {AW{1'b0}};
            sy2_q <= {AW{1'b0}};
            sy3_q <= {AW{1'b0}};
        end
        else
        begin
            sy1_q <= asy_in;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    wire external_interrupt_line_any  = |sy2_q[NEXTI-1:0];
    wire pin2_rise = sy2_q[NEXTI] & ~sy3_q[NEXTI];
    wire pin3_rise = sy2_q[NEXTI+1] & ~sy3_q[NEXTI+1];
    wire alarm_a   = sy2_q[NEXTI+2];
    wire alarm_b   = sy2_q[NEXTI+3];
    wire wake_tmr  = sy2_q[NEXTI+4];
    wire tamper    = sy2_q[NEXTI+5];
    wire tamper_rs = sy2_q[NEXTI+5] & ~sy3_q[NEXTI+5];
    wire tstamp    = sy2_q[NEXTI+6];
    wire rst_pin   = sy2_q[NEXTI+7];
    wire wdog      = sy2_q[NEXTI+8];

    // Registers
    reg [`LPW_CTRL_W-1:0] ctrl_q;
    reg [NPER-1:0]        pclk_reg_q;
    reg [`LPW_IRQ_W-1:0]  irq_stat_q;
    reg [`LPW_IRQ_W-1:0]  irq_mask_q;
    reg                   irq_q;

    wire       c_ulp     = ctrl_q[`LPW_C_ULP];
    wire       c_fwu     = ctrl_q[`LPW_C_FWU];
    wire [1:0] c_vos     = ctrl_q[`LPW_C_VOS_HI:`LPW_C_VOS_LO];
    wire       c_low_power_run_select   = ctrl_q[`LPW_C_LOW_POWER_RUN_SELECT];
    wire       c_wake_pin2_enable   = ctrl_q[`LPW_C_WAKE_PIN2_ENABLE];
    wire       c_wake_pin3_enable   = ctrl_q[`LPW_C_WAKE_PIN3_ENABLE];
    wire [1:0] c_mode    = ctrl_q[`LPW_C_MODE_HI:`LPW_C_MODE_LO];
    wire       c_lpsleep = ctrl_q[`LPW_C_LPSLEEP];

    // AHB-Lite slave
    reg         wr_pend_q;
    reg [11:0]  wr_addr_q;
    reg [31:0]  hrdata_q;
    reg [31:0]  rd_mux;
    reg [31:0]  stat_w;
    wire [31:0] bkp_rdata;

    wire ap_sel  = HSEL & HTRANS[1] & (HSIZE == 3'h2);
    wire rd_wait = wr_pend_q & ap_sel & ~HWRITE;
    wire ap      = ap_sel & HREADY & ~rd_wait;
    wire wr_do   = wr_pend_q;

    wire wr_ctrl = wr_do & (wr_addr_q == `LPW_OFS_CTRL);
    wire wr_ist  = wr_do & (wr_addr_q == `LPW_OFS_IRQ_STAT);
    wire wr_imsk = wr_do & (wr_addr_q == `LPW_OFS_IRQ_MASK);
    wire wr_pclk = wr_do & (wr_addr_q == `LPW_OFS_PCLK);
    wire wr_bkp  = wr_do & (wr_addr_q[11:8] == `LPW_OFS_BKP_PAGE)
                   & ~wr_addr_q[7];

    assign HREADYOUT = ~rd_wait;
    assign HRESP     = 1'b0;
    assign HRDATA    = hrdata_q;

    // Power state
    reg [2:0]  st_q;
    reg [2:0]  st_d;
    reg [3:0]  src_q;
    reg [3:0]  src_d;
    reg [15:0] ref_cnt_q;
    reg [1:0]  range_q;
    reg        regulator_changing_flag_q;
    reg [15:0] setl_cnt_q;
    reg        in_low_power_run_flag_q;
    reg        halt_q;
    reg        cclk_q;
    reg        vcore_q;
    reg        ref_q;
    reg        srst_q;
    reg [NPER-1:0] pclk_q;

    wire ref_rdy  = (ref_cnt_q == REF_CYC);
    wire ref_on_d = ~(c_ulp & (st_d == ST_STOP | st_d == ST_STBY));
    wire ev_wake  = (st_q == ST_SLEEP | st_q == ST_WAKE) & (st_d == ST_RUN);
    wire ev_range = regulator_changing_flag_q & (setl_cnt_q == SETL_CYC - 16'h1);

    always @*
    begin
        st_d  = st_q;
        src_d = src_q;
        case (st_q)
            ST_RUN:
            begin
                if (CORE_SLEEP_REQ)
                begin
                    case (c_mode)
                        `LPW_MODE_STOP: st_d = ST_STOP;
                        `LPW_MODE_STBY: st_d = ST_STBY;
                        default:        st_d = ST_SLEEP;
                    endcase
                end
            end
            ST_SLEEP:
            begin
                if (|PERIPH_IRQ | |PERIPH_WAKE)
                begin
                    st_d  = ST_RUN;
                    src_d = `LPW_SRC_PERIPH;
                end
            end
            ST_STOP:
            begin
                if (external_interrupt_line_any)
                begin
                    st_d  = ST_WAKE;
                    src_d = `LPW_SRC_EXTERNAL_INTERRUPT_LINE;
                end
            end
            ST_STBY:
            begin
                st_d = ST_WAKE;
                if (pin2_rise & c_wake_pin2_enable)
                    src_d = `LPW_SRC_PIN2;
                else if (pin3_rise & c_wake_pin3_enable)
                    src_d = `LPW_SRC_PIN3;
                else if (alarm_a)
                    src_d = `LPW_SRC_ALARM_A;
                else if (alarm_b)
                    src_d = `LPW_SRC_ALARM_B;
                else if (wake_tmr)
                    src_d = `LPW_SRC_WAKE_TMR;
                else if (tamper)
                    src_d = `LPW_SRC_TAMPER;
                else if (tstamp)
                    src_d = `LPW_SRC_TSTAMP;
                else if (rst_pin)
                    src_d = `LPW_SRC_RST_PIN;
                else if (wdog)
                    src_d = `LPW_SRC_WDOG;
                else
                    st_d = ST_STBY;
            end
            ST_WAKE:
            begin
                if (c_fwu | ref_rdy)
                    st_d = ST_RUN;
            end
            default:
                st_d = ST_RUN;
        endcase
    end

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_q    <= ST_RUN;
            src_q   <= `LPW_SRC_NONE;
            halt_q  <= 1'b0;
            cclk_q  <= 1'b1;
            vcore_q <= 1'b1;
            ref_q   <= 1'b1;
            srst_q  <= 1'b0;
            in_low_power_run_flag_q <= 1'b0;
            pclk_q  <= {NPER{1'b1}};
        end
        else
        begin
            st_q    <= st_d;
            src_q   <= src_d;
            // Core released only once its clock has run in wake or sleep state
            halt_q  <= (st_d != ST_RUN);
            cclk_q  <= (st_d != ST_STOP) & (st_d != ST_STBY);
            vcore_q <= (st_d != ST_STBY);
            ref_q   <= ref_on_d;
            srst_q  <= (st_q == ST_STBY) & (st_d == ST_WAKE);
            in_low_power_run_flag_q <= c_low_power_run_select & ((st_d == ST_RUN) | (st_d == ST_SLEEP));
            if (st_d == ST_RUN)
                pclk_q <= pclk_reg_q;
            else if (st_d == ST_SLEEP & ~c_lpsleep)
                pclk_q <= pclk_reg_q;
            else
                pclk_q <= {NPER{1'b0}};
        end
    end

    // Reference start-up counter
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ref_cnt_q <= 16'h0;
        else if (!ref_q)
            ref_cnt_q <= 16'h0;
        else if (!ref_rdy)
            ref_cnt_q <= ref_cnt_q + 16'h1;
    end

    // Regulator range change
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            range_q    <= `LPW_RANGE_RST;
            regulator_changing_flag_q     <= 1'b0;
            setl_cnt_q <= 16'h0;
        end
        else if (!regulator_changing_flag_q)
        begin
            setl_cnt_q <= 16'h0;
            if (c_vos != range_q)
                regulator_changing_flag_q <= 1'b1;
        end
        else if (ev_range)
        begin
            range_q <= c_vos;
            regulator_changing_flag_q  <= 1'b0;
        end
        else
            setl_cnt_q <= setl_cnt_q + 16'h1;
    end

    // Register writes and interrupts
    wire [`LPW_IRQ_W-1:0] ev_vec;

    assign ev_vec[`LPW_I_WAKE]   = ev_wake;
    assign ev_vec[`LPW_I_RANGE]  = ev_range;
    assign ev_vec[`LPW_I_TAMPER] = tamper_rs;

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl_q     <= `LPW_CTRL_RST;
            pclk_reg_q <= {NPER{1'b1}};
            irq_stat_q <= `LPW_IRQ_RST;
            irq_mask_q <= `LPW_IRQ_RST;
            irq_q      <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= HWDATA[`LPW_CTRL_W-1:0];
            if (wr_pclk)
                pclk_reg_q <= HWDATA[NPER-1:0];
            if (wr_imsk)
                irq_mask_q <= HWDATA[`LPW_IRQ_W-1:0];
            // Set wins over write-one-to-clear
            irq_stat_q <= (irq_stat_q
                           & ~({`LPW_IRQ_W{wr_ist}} & HWDATA[`LPW_IRQ_W-1:0]))
                          | ev_vec;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Status and read mux
    always @*
    begin
        stat_w = 32'h0;
        stat_w[`LPW_S_REFRDY] = ref_rdy;
        stat_w[`LPW_S_REGULATOR_CHANGING_FLAG]   = regulator_changing_flag_q;
        stat_w[`LPW_S_IN_LOW_POWER_RUN_FLAG]  = in_low_power_run_flag_q;
        stat_w[`LPW_S_STATE_HI:`LPW_S_STATE_LO] = st_q;
        stat_w[`LPW_S_SRC_HI:`LPW_S_SRC_LO]     = src_q;
    end

    always @*
    begin
        rd_mux = 32'h0;
        case (HADDR)
            `LPW_OFS_CTRL:     rd_mux[`LPW_CTRL_W-1:0] = ctrl_q;
            `LPW_OFS_STAT:     rd_mux = stat_w;
            `LPW_OFS_IRQ_STAT: rd_mux[`LPW_IRQ_W-1:0] = irq_stat_q;
            `LPW_OFS_IRQ_MASK: rd_mux[`LPW_IRQ_W-1:0] = irq_mask_q;
            `LPW_OFS_PCLK:     rd_mux[NPER-1:0] = pclk_reg_q;
            default:
            begin
                if (HADDR[11:8] == `LPW_OFS_BKP_PAGE & ~HADDR[7])
                    rd_mux = bkp_rdata;
            end
        endcase
    end

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h0;
            hrdata_q  <= 32'h0;
        end
        else
        begin
            if (HREADY)
                wr_pend_q <= ap & HWRITE;
            if (ap)
                wr_addr_q <= HADDR;
            if (ap & ~HWRITE)
                hrdata_q <= rd_mux;
        end
    end

    lpw_bkp #(
        .WORDS (`LPW_BKP_WORDS)
    ) u_bkp (
        .clk    (CLK),
        .arst_n (ARST_N),
        .clr    (tamper),
        .we     (wr_bkp),
        .waddr  (wr_addr_q[6:2]),
        .wdata  (HWDATA),
        .raddr  (HADDR[6:2]),
        .rdata  (bkp_rdata)
    );

    assign CORE_HALT      = halt_q;
    assign CORE_CLK_EN    = cclk_q;
    assign PCLK_EN        = pclk_q;
    assign REF_EN         = ref_q;
    assign VCORE_EN       = vcore_q;
    assign REG_RANGE      = range_q;
    assign LP_RUN         = in_low_power_run_flag_q;
    assign STBY_RESET_REQ = srst_q;
    assign IRQ            = irq_q;
endmodule

// ---- lpw_ctrl_partner.sv ----
`timescale 1ns/1ps
module lpw_ctrl_partner #(
    parameter NPER  = 8,
    parameter NEXTI = 16
) (
    input  wire              clk,
    output logic             sleep_req,
    output logic [NPER-1:0]  pirq,
    output logic [NPER-1:0]  pwake,
    output logic [NEXTI-1:0] external_interrupt_line,
    output logic [11:3]      src
);
    initial
    begin
        sleep_req = 1'b0;
        pirq = '0;
        pwake = '0;
        external_interrupt_line = '0;
        src = '0;
    end
    // Core runs the wait instruction: one-cycle request
    task doze;
    begin
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge clk);
    end
    endtask
    // Source k rises from idle after d cycles and holds six cycles
    task fire(input int k, input logic [31:0] r, input int d);
    begin
        repeat (d) @(posedge clk);
        if (k == 1 && r[31])
            pwake[r % NPER] <= 1'b1;
        else if (k == 1)
            pirq[r % NPER] <= 1'b1;
        else if (k == 2)
            external_interrupt_line[r % NEXTI] <= 1'b1;
        else
            src[k] <= 1'b1;
        repeat (6) @(posedge clk);
        pirq <= '0;
        pwake <= '0;
        external_interrupt_line <= '0;
        src <= '0;
        @(posedge clk);
    end
    endtask
endmodule

// ---- lpw_ctrl_properties.sv ----
`timescale 1ns/1ps
module lpw_ctrl_properties #(
    parameter NPER  = 8,
    parameter NEXTI = 16
) (
    input wire             CLK,
    input wire             ARST_N,
    input wire [NPER-1:0]  PERIPH_IRQ,
    input wire [NPER-1:0]  PERIPH_WAKE,
    input wire [NEXTI-1:0] EXTERNAL_INTERRUPT_LINE_LINE,
    input wire             CAL_ALARM_A,
    input wire             CAL_ALARM_B,
    input wire             CAL_WAKE_TIMER,
    input wire             CAL_TAMPER,
    input wire             CAL_TIMESTAMP,
    input wire             EXT_RESET_PIN_N,
    input wire             WATCHDOG_RESET,
    input wire             CORE_HALT,
    input wire             CORE_CLK_EN,
    input wire [NPER-1:0]  PCLK_EN,
    input wire             REF_EN,
    input wire             VCORE_EN,
    input wire [1:0]       REG_RANGE,
    input wire             LP_RUN,
    input wire             STBY_RESET_REQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    logic sleep_q;
    wire  cal_ev = CAL_ALARM_A | CAL_ALARM_B | CAL_WAKE_TIMER
                 | CAL_TAMPER | CAL_TIMESTAMP;
    // Halted with core clock on, entered straight from run: sleep
    always @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            sleep_q <= 1'b0;
        else
            sleep_q <= CORE_HALT
                       && (sleep_q || (CORE_CLK_EN && $rose(CORE_HALT)));
    sequence s_stop_event;
        CORE_HALT && !CORE_CLK_EN && VCORE_EN && |EXTERNAL_INTERRUPT_LINE_LINE;
    endsequence
    sequence s_stby_exit;
        ##[1:4] STBY_RESET_REQ ##[0:2] VCORE_EN;
    endsequence
    AST_SLEEP_WAKE: assert property (
        sleep_q && CORE_HALT && |(PERIPH_IRQ | PERIPH_WAKE) |=> !CORE_HALT)
        else $error("sleep not left on peripheral event");
    AST_STOP_WAKE: assert property (
        s_stop_event |-> ##[1:4] CORE_CLK_EN)
        else $error("stop not left on external line");
    AST_STBY_CAL: assert property (
        !VCORE_EN && cal_ev |-> s_stby_exit)
        else $error("standby not left on calendar event");
    AST_STBY_RST: assert property (
        !VCORE_EN && (!EXT_RESET_PIN_N || WATCHDOG_RESET) |-> s_stby_exit)
        else $error("standby not left on reset source");
    AST_SLEEP_GATE: assert property (
        sleep_q && CORE_HALT |=> !CORE_HALT || $stable(PCLK_EN))
        else $error("peripheral gates moved during sleep");
    AST_REF_OFF: assert property (
        !REF_EN |-> CORE_HALT && !sleep_q)
        else $error("reference off outside stop or standby");
    AST_CLK_FIRST: assert property (
        $fell(CORE_HALT) |-> CORE_CLK_EN && VCORE_EN && $past(CORE_CLK_EN))
        else $error("core released before clock restored");
    AST_STBY_PULSE: assert property (
        STBY_RESET_REQ |-> !$past(VCORE_EN) ##1 !STBY_RESET_REQ)
        else $error("standby exit pulse misplaced");
    AST_LP_RUN: assert property (
        LP_RUN |-> CORE_CLK_EN && VCORE_EN)
        else $error("low-power run flag outside run or sleep");
    AST_RANGE_HOLD: assert property (
        !$stable(REG_RANGE) |=> $stable(REG_RANGE) [*8])
        else $error("regulator range changed twice quickly");
endmodule
bind lpw_ctrl lpw_ctrl_properties #(.NPER(NPER), .NEXTI(NEXTI)) u_props (
    .CLK(CLK), .ARST_N(ARST_N), .PERIPH_IRQ(PERIPH_IRQ),
    .PERIPH_WAKE(PERIPH_WAKE), .EXTERNAL_INTERRUPT_LINE_LINE(EXTERNAL_INTERRUPT_LINE_LINE),
    .CAL_ALARM_A(CAL_ALARM_A), .CAL_ALARM_B(CAL_ALARM_B),
    .CAL_WAKE_TIMER(CAL_WAKE_TIMER), .CAL_TAMPER(CAL_TAMPER),
    .CAL_TIMESTAMP(CAL_TIMESTAMP), .EXT_RESET_PIN_N(EXT_RESET_PIN_N),
    .WATCHDOG_RESET(WATCHDOG_RESET), .CORE_HALT(CORE_HALT),
    .CORE_CLK_EN(CORE_CLK_EN), .PCLK_EN(PCLK_EN), .REF_EN(REF_EN),
    .VCORE_EN(VCORE_EN), .REG_RANGE(REG_RANGE), .LP_RUN(LP_RUN),
    .STBY_RESET_REQ(STBY_RESET_REQ)
);

// ---- lpw_ctrl_tb.sv ----
`timescale 1ns/1ps
module lpw_ctrl_tb;
    logic        CLK;
    logic        ARST_N;
    logic        HSEL;
    logic [11:0] HADDR;
    logic [1:0]  HTRANS;
    logic        HWRITE;
    logic [2:0]  HSIZE;
    logic [31:0] HWDATA;
    wire         HREADYOUT;
    wire         HRESP;
    wire  [31:0] HRDATA;
    wire         CORE_SLEEP_REQ;
    wire  [7:0]  PERIPH_IRQ;
    wire  [7:0]  PERIPH_WAKE;
    wire  [15:0] EXTERNAL_INTERRUPT_LINE_LINE;
    wire  [11:3] src;
    wire         CORE_HALT;
    wire         CORE_CLK_EN;
    wire  [7:0]  PCLK_EN;
    wire         REF_EN;
    wire         VCORE_EN;
    wire  [1:0]  REG_RANGE;
    wire         LP_RUN;
    wire         STBY_RESET_REQ;
    wire         IRQ;
    int          failures;
    int          total_checks;
    int          cyc;
    int          stby_pulses;
    int          n;
    int          i;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [31:0] m_pclk;
    logic [31:0] m_bkp [20];
    lpw_ctrl DUT (
        .CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .CORE_SLEEP_REQ(CORE_SLEEP_REQ),
        .PERIPH_IRQ(PERIPH_IRQ), .PERIPH_WAKE(PERIPH_WAKE),
        .EXTERNAL_INTERRUPT_LINE_LINE(EXTERNAL_INTERRUPT_LINE_LINE), .WAKE_PIN2(src[3]), .WAKE_PIN3(src[4]),
        .CAL_ALARM_A(src[5]), .CAL_ALARM_B(src[6]),
        .CAL_WAKE_TIMER(src[7]), .CAL_TAMPER(src[8]),
        .CAL_TIMESTAMP(src[9]), .EXT_RESET_PIN_N(!src[10]),
        .WATCHDOG_RESET(src[11]), .CORE_HALT(CORE_HALT),
        .CORE_CLK_EN(CORE_CLK_EN), .PCLK_EN(PCLK_EN), .REF_EN(REF_EN),
        .VCORE_EN(VCORE_EN), .REG_RANGE(REG_RANGE), .LP_RUN(LP_RUN),
        .STBY_RESET_REQ(STBY_RESET_REQ), .IRQ(IRQ)
    );
    lpw_ctrl_partner u_src (
        .clk(CLK), .sleep_req(CORE_SLEEP_REQ), .pirq(PERIPH_IRQ),
        .pwake(PERIPH_WAKE), .external_interrupt_line(EXTERNAL_INTERRUPT_LINE_LINE), .src(src)
    );
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    // Standby exit pulses seen by the bench
    always @(posedge CLK)
        if (STBY_RESET_REQ === 1'b1)
            stby_pulses <= stby_pulses + 1;
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    // One single word transfer; read data lands in rd
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
        HSEL <= 1'b1;
        HADDR <= a;
        HWRITE <= w;
        HTRANS <= 2'h2;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
    end
    endtask
    task nap_in(input logic [31:0] c);
    begin
        ahb(1'b1, 12'h000, c);
        ahb(1'b0, 12'h000, 32'h0);
        chk_reg(rd, c);
        u_src.doze();
        chk_pin(CORE_HALT, 1'b1);
    end
    endtask
    task nap_out(input int k, input int d);
    begin
        u_src.fire(k, $random(seed), d);
        for (n = 0; CORE_HALT !== 1'b0 && n < 400; n++) @(posedge CLK);
        ahb(1'b0, 12'h004, 32'h0);
        chk_reg({28'h0, rd[11:8]}, k);
    end
    endtask
    task bkp_cmp;
        for (i = 0; i < 20; i++)
        begin
            ahb(1'b0, 12'(256 + 4 * i), 32'h0);
            chk_reg(rd, m_bkp[i]);
        end
    endtask
    initial
    begin
        {HSEL, HADDR, HTRANS, HWRITE, HWDATA} = '0;
        HSIZE = 3'h2;
        seed = 32'h86a8d063;
        {failures, total_checks, cyc, stby_pulses} = '0;
        ARST_N = 1'b0;
        repeat (20) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        ahb(1'b0, 12'h010, 32'h0);
        chk_reg(rd, 32'hff);
        ahb(1'b1, 12'h0f0, 32'hffffffff);
        ahb(1'b0, 12'h0f0, 32'h0);
        chk_reg(rd, 32'h0);
        chk_pin(HRESP, 1'b0);
        chk_reg({30'h0, REG_RANGE}, 32'h1);
        for (i = 0; i < 20; i++)
        begin
            m_bkp[i] = $random(seed);
            ahb(1'b1, 12'(256 + 4 * i), m_bkp[i]);
        end
        bkp_cmp();
        u_src.fire(8, 32'h0, 0);
        for (i = 0; i < 20; i++)
            m_bkp[i] = 32'h0;
        bkp_cmp();
        m_pclk = $random(seed) & 32'hff;
        ahb(1'b1, 12'h010, m_pclk);
        nap_in(32'h004);
        chk_reg({24'h0, PCLK_EN}, m_pclk);
        nap_out(1, 3);
        nap_in(32'h404);
        chk_reg({24'h0, PCLK_EN}, 32'h0);
        nap_out(1, 0);
        chk_reg({24'h0, PCLK_EN}, m_pclk);
        ahb(1'b1, 12'h00c, 32'h1);
        nap_in(32'h104);
        chk_reg({30'h0, CORE_CLK_EN, REF_EN}, 32'h1);
        nap_out(2, 2);
        repeat (2) @(posedge CLK);
        chk_pin(IRQ, 1'b1);
        ahb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge CLK);
        chk_pin(IRQ, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            nap_in(32'h105 | (i << 1));
            chk_pin(REF_EN, 1'b0);
            nap_out(2, 0);
            chk_pin(n > 100, i == 0);
        end
        for (i = 3; i < 12; i++)
        begin
            nap_in(32'h264);
            chk_pin(VCORE_EN, 1'b0);
            nap_out(i, i % 3);
        end
        nap_in(32'h244);
        u_src.fire(3, 32'h0, 0);
        chk_pin(CORE_HALT, 1'b1);
        nap_out(4, 0);
        chk_reg(stby_pulses, 32'd10);
        ahb(1'b1, 12'h000, 32'h8);
        @(posedge CLK);
        ahb(1'b0, 12'h004, 32'h0);
        chk_reg({30'h0, rd[1], REG_RANGE[1]}, 32'h2);
        repeat (60) @(posedge CLK);
        ahb(1'b0, 12'h004, 32'h0);
        chk_reg({29'h0, rd[1:0], REG_RANGE[1]}, 32'h3);
        ahb(1'b1, 12'h000, 32'h18);
        repeat (2) @(posedge CLK);
        ahb(1'b0, 12'h004, 32'h0);
        chk_reg({30'h0, rd[2], LP_RUN}, 32'h3);
        wrap_up();
    end
endmodule

// ---- lpw_defines.vh ----
`ifndef LPW_DEFINES_VH
`define LPW_DEFINES_VH

// Register byte offsets, backup page number and backup word count
`define LPW_OFS_CTRL      12'h000
`define LPW_OFS_STAT      12'h004
`define LPW_OFS_IRQ_STAT  12'h008
`define LPW_OFS_IRQ_MASK  12'h00c
`define LPW_OFS_PCLK      12'h010
`define LPW_OFS_BKP_PAGE  4'h1
`define LPW_BKP_WORDS     20

// Control register fields
`define LPW_C_ULP         0
`define LPW_C_FWU         1
`define LPW_C_VOS_LO      2
`define LPW_C_VOS_HI      3
`define LPW_C_LOW_POWER_RUN_SELECT       4
`define LPW_C_WAKE_PIN2_ENABLE       5
`define LPW_C_WAKE_PIN3_ENABLE       6
`define LPW_C_MODE_LO     8
`define LPW_C_MODE_HI     9
`define LPW_C_LPSLEEP     10
`define LPW_CTRL_W        11
`define LPW_CTRL_RST      11'h004

// Status register fields
`define LPW_S_REFRDY      0
`define LPW_S_REGULATOR_CHANGING_FLAG        1
`define LPW_S_IN_LOW_POWER_RUN_FLAG       2
`define LPW_S_STATE_LO    4
`define LPW_S_STATE_HI    6
`define LPW_S_SRC_LO      8
`define LPW_S_SRC_HI      11

// Interrupt status fields
`define LPW_I_WAKE        0
`define LPW_I_RANGE       1
`define LPW_I_TAMPER      2
`define LPW_IRQ_W         3
`define LPW_IRQ_RST       3'h0

// Low-power mode requests
`define LPW_MODE_SLEEP    2'h0
`define LPW_MODE_STOP     2'h1
`define LPW_MODE_STBY     2'h2

// Regulator range after reset
`define LPW_RANGE_RST     2'h1

// Wake-up source codes
`define LPW_SRC_NONE      4'h0
`define LPW_SRC_PERIPH    4'h1
`define LPW_SRC_EXTERNAL_INTERRUPT_LINE      4'h2
`define LPW_SRC_PIN2      4'h3
`define LPW_SRC_PIN3      4'h4
`define LPW_SRC_ALARM_A   4'h5
`define LPW_SRC_ALARM_B   4'h6
`define LPW_SRC_WAKE_TMR  4'h7
`define LPW_SRC_TAMPER    4'h8
`define LPW_SRC_TSTAMP    4'h9
`define LPW_SRC_RST_PIN   4'ha
`define LPW_SRC_WDOG      4'hb

// Timing
`define LPW_CLK_MHZ         50
`define LPW_REF_START_NS    3000
`define LPW_RANGE_SETTLE_NS 1000
`define LPW_REF_CYC \
    ((`LPW_REF_START_NS * `LPW_CLK_MHZ + 999) / 1000)
`define LPW_SETTLE_CYC \
    ((`LPW_RANGE_SETTLE_NS * `LPW_CLK_MHZ + 999) / 1000)

`endif
